// file: tb_wdf_watchdog.sv
module tb_wdf_watchdog;
	timeunit 1ns;
	timeprecision 1ps;
	// A short prescale keeps every overflow within a few hundred cycles.
	localparam int PS = 2;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [wdf_pkg::ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hf;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	logic chip_reset;
	logic [1:0] watchdog_priority;
	logic [7:0] flash_command;
	int error_cnt = 0;
	int total_checks = 0;
	int resets = 0;
	logic [31:0] rdv;
	logic errv;

	wdf_watchdog #(.PRESCALE(PS)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.chip_reset(chip_reset), .watchdog_priority(watchdog_priority),
		.flash_command(flash_command));

	always #20 pclk = ~pclk;

	always @(posedge pclk)
		if (chip_reset === 1'b1)
			resets <= resets + 1;

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : give_verdict

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Idle edge first, so a release and the next setup never share a time step.
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1);
		// One wait state: pready is seen at the second edge of the access phase.
		chk("wait states", 32'h2, n);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : bus

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d);
	endtask : wr

	task automatic rdc(input string nm, input logic [7:0] idx, input logic [7:0] e,
		input logic [7:0] m = 8'hff);
		bus(1'b0, idx, 8'h00);
		chk(nm, {24'h0, e}, rdv & {24'h0, m});
	endtask : rdc

	task automatic feed();
		wr(wdf_pkg::IDX_FEED_FIRST, wdf_pkg::FEED_KEY_FIRST);
		wr(wdf_pkg::IDX_FEED_SECOND, wdf_pkg::FEED_KEY_SECOND);
	endtask : feed

	task automatic idle(input int n);
		repeat (n) @(posedge pclk);
	endtask : idle

	initial
	begin
		#400000;
		error_cnt++;
		give_verdict();
	end

	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rdc("ctl", wdf_pkg::IDX_CONTROL, 8'h00);
		rdc("feed1", wdf_pkg::IDX_FEED_FIRST, 8'h00);
		rdc("feed2", wdf_pkg::IDX_FEED_SECOND, 8'h00);
		rdc("istat", wdf_pkg::IDX_IRQ_STATUS, 8'h00);
		bus(1'b0, 8'h10, 8'h00);
		chk("unmapped err", 32'h1, {31'h0, errv});
		chk("unmapped data", 32'h0, rdv);
		pstrb <= 4'he;
		wr(wdf_pkg::IDX_RELOAD, 8'h33);
		pstrb <= 4'hf;
		rdc("reload strb", wdf_pkg::IDX_RELOAD, 8'h00);
		wr(wdf_pkg::IDX_RELOAD, 8'hc0);
		$display("test reset and map done");
		wr(wdf_pkg::IDX_FLASH_CMD, 8'h3c);
		rdc("flash unfed", wdf_pkg::IDX_FLASH_CMD, 8'h00);
		feed();
		wr(wdf_pkg::IDX_FLASH_CMD, 8'h3c);
		rdc("flash fed", wdf_pkg::IDX_FLASH_CMD, 8'h3c);
		chk("flash port", 32'h3c, {24'h0, flash_command});
		wr(wdf_pkg::IDX_FEED_FIRST, wdf_pkg::FEED_KEY_FIRST);
		wr(wdf_pkg::IDX_RELOAD, 8'hc0);
		wr(wdf_pkg::IDX_FEED_SECOND, wdf_pkg::FEED_KEY_SECOND);
		wr(wdf_pkg::IDX_FLASH_CMD, 8'h77);
		rdc("flash broken", wdf_pkg::IDX_FLASH_CMD, 8'h3c);
		wr(wdf_pkg::IDX_CONTROL, 8'h01);
		rdc("ctl unfed idle", wdf_pkg::IDX_CONTROL, 8'h00);
		chk("no reset", 32'h0, resets);
		$display("test feed guard done");
		// Reload c0 gives 128 cycles per overflow; reads land well either side.
		feed();
		wr(wdf_pkg::IDX_CONTROL, 8'h01);
		idle(100);
		rdc("before ovf", wdf_pkg::IDX_CONTROL, 8'h01);
		feed();
		wr(wdf_pkg::IDX_CONTROL, 8'h03);
		rdc("refresh clr", wdf_pkg::IDX_CONTROL, 8'h01);
		idle(100);
		rdc("refreshed", wdf_pkg::IDX_CONTROL, 8'h01);
		idle(40);
		rdc("ovf status", wdf_pkg::IDX_CONTROL, 8'h05);
		wr(wdf_pkg::IDX_CLOCK_GATE, 8'h20);
		feed();
		wr(wdf_pkg::IDX_CONTROL, 8'h07);
		idle(200);
		rdc("clock stop", wdf_pkg::IDX_CONTROL, 8'h01);
		wr(wdf_pkg::IDX_CLOCK_GATE, 8'h00);
		idle(140);
		rdc("clock run", wdf_pkg::IDX_CONTROL, 8'h05);
		chk("no ovf reset", 32'h0, resets);
		feed();
		wr(wdf_pkg::IDX_CONTROL, 8'h04);
		rdc("stop clear", wdf_pkg::IDX_CONTROL, 8'h00);
		$display("test counting done");
		wr(wdf_pkg::IDX_RELOAD, 8'hfc);
		feed();
		wr(wdf_pkg::IDX_CONTROL, 8'h09);
		idle(30);
		chk("ovf reset", 32'h1, resets);
		rdc("status kept", wdf_pkg::IDX_CONTROL, 8'h04);
		feed();
		wr(wdf_pkg::IDX_CONTROL, 8'h40);
		rdc("lock on", wdf_pkg::IDX_CONTROL, 8'h41, 8'h41);
		feed();
		wr(wdf_pkg::IDX_CONTROL, 8'h00);
		rdc("lock held", wdf_pkg::IDX_CONTROL, 8'h40, 8'h40);
		wr(wdf_pkg::IDX_CONTROL, 8'h00);
		idle(2);
		chk("bad feed reset", 32'h2, resets);
		rdc("feed err", wdf_pkg::IDX_CONTROL, 8'h20, 8'h61);
		$display("test reset paths done");
		rdc("istat", wdf_pkg::IDX_IRQ_STATUS, 8'h03);
		wr(wdf_pkg::IDX_IRQ_MASK, 8'h01);
		wr(wdf_pkg::IDX_IRQ_ENABLE, 8'h40);
		idle(2);
		chk("irq on", 32'h1, {31'h0, irq});
		wr(wdf_pkg::IDX_IRQ_ENABLE, 8'h00);
		idle(2);
		chk("irq disabled", 32'h0, {31'h0, irq});
		wr(wdf_pkg::IDX_IRQ_ENABLE, 8'h40);
		wr(wdf_pkg::IDX_IRQ_MASK, 8'h00);
		idle(2);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(wdf_pkg::IDX_IRQ_STATUS, 8'h03);
		rdc("istat clr", wdf_pkg::IDX_IRQ_STATUS, 8'h00);
		wr(wdf_pkg::IDX_IRQ_MASK, 8'h03);
		idle(2);
		chk("irq cleared", 32'h0, {31'h0, irq});
		for (int i = 0; i < 4; i++)
		begin
			wr(wdf_pkg::IDX_PRIO_HIGH, {1'b0, i[1], 6'h00});
			wr(wdf_pkg::IDX_PRIO_LOW, {1'b0, i[0], 6'h00});
			idle(2);
			chk("priority", i, {30'h0, watchdog_priority});
		end
		$display("test interrupt done");
		// Status and feed error are both set here, so a clean read shows the reset.
		presetn <= 1'b0;
		idle(2);
		presetn <= 1'b1;
		rdc("ctl after reset", wdf_pkg::IDX_CONTROL, 8'h00);
		chk("flash after reset", 32'h0, {24'h0, flash_command});
		$display("test external reset done");
		give_verdict();
	end
endmodule : tb_wdf_watchdog

// file: wdf_pkg.sv
// How it works
// R1: Both feed keys must be written, in order, before a control or flash command write.
// R2: A flash command write without a completed feed is dropped unchanged.
// R3: An unfed control write while the watchdog runs raises a chip reset at once.
// R4: Writing lock-on starts the watchdog; software can never clear lock-on.
// R5: A reset caused by a bad feed sets the feed-error flag.
// R6: Reset-enable decides whether counter overflow asserts the chip reset.
// R7: Every counter overflow sets the watchdog reset status flag.
// R8: Power-on or external reset clears the watchdog reset status flag.
// R9: Writing one to the status flag clears it.
// R10: A chip reset caused by overflow leaves the status flag set.
// R11: Refresh bit reloads the counter, then hardware clears the bit.
// R12: Clock-stop bit in the clock gate register freezes the watchdog count.
// R13: Watchdog priority is bit 6 of the high and low priority registers.
// R14: The watchdog interrupt leaves the block only while its enable bit is set.
// R15: Run bit one counts, run bit zero halts the counter; here the run bit stays one while lock-on is set, so the counter keeps counting.
// R16: Start and refresh reload the counter from the reload register.
package wdf_pkg;
	// Register indices; byte address is four times the index.
	localparam logic [7:0] IDX_RELOAD = 8'h85;
	localparam logic [7:0] IDX_PRIO_LOW = 8'h91;
	localparam logic [7:0] IDX_PRIO_HIGH = 8'h92;
	localparam logic [7:0] IDX_FEED_FIRST = 8'h97;
	localparam logic [7:0] IDX_CLOCK_GATE = 8'ha1;
	localparam logic [7:0] IDX_CONTROL = 8'hc0;
	localparam logic [7:0] IDX_FEED_SECOND = 8'hc4;
	localparam logic [7:0] IDX_IRQ_ENABLE = 8'he8;
	localparam logic [7:0] IDX_FLASH_CMD = 8'hf0;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'hf1;
	localparam logic [7:0] IDX_IRQ_MASK = 8'hf2;
	// Control register fields.
	localparam int BIT_RUN = 0;
	localparam int BIT_REFRESH = 1;
	localparam int BIT_STATUS = 2;
	localparam int BIT_RESET_EN = 3;
	localparam int BIT_FEED_ERR = 5;
	localparam int BIT_LOCK = 6;
	// Other fields.
	localparam int BIT_CLOCK_STOP = 5;
	localparam int BIT_WD_PRIO = 6;
	localparam int BIT_WD_IRQ_EN = 6;
	localparam int IRQ_OVERFLOW = 0;
	localparam int IRQ_FEED_ERR = 1;
	// Reset values.
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [1:0] RST_IRQ = 2'h0;
	// Feed keys; values are arbitrary.
	localparam logic [7:0] FEED_KEY_FIRST = 8'h5a;
	localparam logic [7:0] FEED_KEY_SECOND = 8'ha5;
	// Pclk cycles per watchdog count step.
	localparam int PRESCALE_CYCLES = 256;
	localparam int ADDR_W = 10;

	typedef enum logic [2:0]
	{
		WDF_IDLE = 3'h1,
		WDF_HALF = 3'h2,
		WDF_ARMED = 3'h4
	} wdf_feed_t;
endpackage : wdf_pkg

// file: wdf_watchdog.sv
module wdf_watchdog #(
	parameter int PRESCALE = wdf_pkg::PRESCALE_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [wdf_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	output logic chip_reset,
	output logic [1:0] watchdog_priority,
	output logic [7:0] flash_command
);
	if (PRESCALE < 1 || PRESCALE > 65536)
	begin : g_bad_prescale
		$error("PRESCALE must lie between 1 and 65536");
	end

	typedef struct packed {
		logic ready;
		logic slverr;
		logic [31:0] rdata;
		logic [7:0] reload;
		logic [7:0] prio_low;
		logic [7:0] prio_high;
		logic [7:0] clock_gate;
		logic [7:0] irq_enable;
		logic [7:0] flash_cmd;
		logic lock;
		logic feed_err;
		logic reset_en;
		logic status;
		logic refresh;
		logic run;
		wdf_pkg::wdf_feed_t feed;
		logic [1:0] irq_stat;
		logic [1:0] irq_mask;
		logic irq;
		logic chip_rst;
		logic [1:0] prio;
		logic [7:0] cnt;
		logic [15:0] pre;
	} wdf_state_t;

	wdf_state_t s_reg;
	wdf_state_t s_next;
	logic done;
	logic wr;
	logic [7:0] idx;
	logic [7:0] wd;
	logic tick;
	logic overflow;
	logic fed;
	logic unfed_ctrl;
	logic ovf_rst;

	assign done = psel && penable && s_reg.ready;
	assign wr = done && pwrite && pstrb[0];
	assign idx = paddr[9:2];
	assign wd = pwdata[7:0];
	assign fed = s_reg.feed == wdf_pkg::WDF_ARMED;
	// Watchdog mode is taken as the counter running.
	assign unfed_ctrl = wr && idx == wdf_pkg::IDX_CONTROL && !fed && s_reg.run;
	assign tick = s_reg.run && !s_reg.clock_gate[wdf_pkg::BIT_CLOCK_STOP]
		&& s_reg.pre == 16'(PRESCALE - 1); // [R12] [R15]
	assign overflow = tick && s_reg.cnt == 8'hff;
	// Helper for the checks: an overflow that resets the chip also drops the feed.
	assign ovf_rst = overflow && s_reg.reset_en;

	always_comb
	begin
		logic [7:0] rd;
		logic hit;
		logic start;
		rd = 8'h00;
		hit = 1'b1;
		start = 1'b0;
		s_next = s_reg;
		s_next.chip_rst = 1'b0;
		s_next.refresh = 1'b0; // [R11]
		// Two-cycle access: pready rises in the second access cycle.
		s_next.ready = psel && penable && !s_reg.ready;
		unique case (idx)
			wdf_pkg::IDX_RELOAD: rd = s_reg.reload;
			wdf_pkg::IDX_PRIO_LOW: rd = s_reg.prio_low;
			wdf_pkg::IDX_PRIO_HIGH: rd = s_reg.prio_high;
			wdf_pkg::IDX_FEED_FIRST: rd = 8'h00;
			wdf_pkg::IDX_FEED_SECOND: rd = 8'h00;
			wdf_pkg::IDX_CLOCK_GATE: rd = s_reg.clock_gate;
			wdf_pkg::IDX_IRQ_ENABLE: rd = s_reg.irq_enable;
			wdf_pkg::IDX_FLASH_CMD: rd = s_reg.flash_cmd;
			wdf_pkg::IDX_IRQ_STATUS: rd = {6'h00, s_reg.irq_stat};
			wdf_pkg::IDX_IRQ_MASK: rd = {6'h00, s_reg.irq_mask};
			wdf_pkg::IDX_CONTROL:
			begin
				rd[wdf_pkg::BIT_RUN] = s_reg.run;
				rd[wdf_pkg::BIT_REFRESH] = s_reg.refresh;
				rd[wdf_pkg::BIT_STATUS] = s_reg.status;
				rd[wdf_pkg::BIT_RESET_EN] = s_reg.reset_en;
				rd[wdf_pkg::BIT_FEED_ERR] = s_reg.feed_err;
				rd[wdf_pkg::BIT_LOCK] = s_reg.lock;
			end
			default: hit = 1'b0;
		endcase
		if (paddr[1:0] != 2'h0)
		begin
			hit = 1'b0;
		end
		if (psel && penable && !s_reg.ready)
		begin
			s_next.rdata = (hit && !pwrite) ? {24'h000000, rd} : 32'h00000000;
			s_next.slverr = !hit;
		end

		// Prescaler and counter.
		if (s_reg.run && !s_reg.clock_gate[wdf_pkg::BIT_CLOCK_STOP])
		begin
			s_next.pre = tick ? 16'h0000 : s_reg.pre + 16'h0001; // [R12]
		end
		if (tick)
		begin
			s_next.cnt = overflow ? s_reg.reload : s_reg.cnt + 8'h01;
		end

		if (wr)
		begin
			unique case (idx)
				wdf_pkg::IDX_RELOAD: s_next.reload = wd;
				wdf_pkg::IDX_PRIO_LOW: s_next.prio_low = wd;
				wdf_pkg::IDX_PRIO_HIGH: s_next.prio_high = wd;
				wdf_pkg::IDX_CLOCK_GATE: s_next.clock_gate = wd;
				wdf_pkg::IDX_IRQ_ENABLE: s_next.irq_enable = wd;
				wdf_pkg::IDX_IRQ_MASK: s_next.irq_mask = wd[1:0];
				wdf_pkg::IDX_IRQ_STATUS: s_next.irq_stat = s_reg.irq_stat & ~wd[1:0];
				wdf_pkg::IDX_FLASH_CMD:
				begin
					if (fed)
					begin
						s_next.flash_cmd = wd; // [R2]
					end
				end
				wdf_pkg::IDX_CONTROL:
				begin
					if (fed)
					begin
						s_next.lock = s_reg.lock || wd[wdf_pkg::BIT_LOCK]; // [R4]
						s_next.run = wd[wdf_pkg::BIT_RUN] || s_next.lock; // [R4] [R15]
						s_next.reset_en = wd[wdf_pkg::BIT_RESET_EN];
						s_next.refresh = wd[wdf_pkg::BIT_REFRESH]; // [R11]
						if (wd[wdf_pkg::BIT_STATUS])
						begin
							s_next.status = 1'b0; // [R9]
						end
						if (wd[wdf_pkg::BIT_FEED_ERR])
						begin
							s_next.feed_err = 1'b0;
						end
						start = s_next.run && !s_reg.run;
					end
				end
				default:
				begin
				end
			endcase
			// Any write other than the expected key breaks a partial feed.
			unique case (s_reg.feed)
				wdf_pkg::WDF_IDLE:
				begin
					if (idx == wdf_pkg::IDX_FEED_FIRST && wd == wdf_pkg::FEED_KEY_FIRST)
					begin
						s_next.feed = wdf_pkg::WDF_HALF; // [R1]
					end
				end
				wdf_pkg::WDF_HALF:
				begin
					if (idx == wdf_pkg::IDX_FEED_SECOND && wd == wdf_pkg::FEED_KEY_SECOND)
					begin
						s_next.feed = wdf_pkg::WDF_ARMED; // [R1]
					end
					else
					begin
						s_next.feed = wdf_pkg::WDF_IDLE;
					end
				end
				wdf_pkg::WDF_ARMED:
				begin
					// The feed is consumed by one guarded write and lost on any other.
					s_next.feed = wdf_pkg::WDF_IDLE; // [R1]
				end
				default: s_next.feed = wdf_pkg::WDF_IDLE;
			endcase
		end

		// Refresh or start reloads the counter and restarts the prescaler.
		if (start || s_reg.refresh)
		begin
			s_next.cnt = s_reg.reload; // [R16] [R11]
			s_next.pre = 16'h0000;
		end

		// Hardware sets win over software clears issued in the same cycle.
		if (overflow)
		begin
			s_next.status = 1'b1; // [R7]
			s_next.irq_stat[wdf_pkg::IRQ_OVERFLOW] = 1'b1;
			s_next.chip_rst = s_reg.reset_en; // [R6]
		end
		if (unfed_ctrl)
		begin
			s_next.feed_err = 1'b1; // [R5]
			s_next.irq_stat[wdf_pkg::IRQ_FEED_ERR] = 1'b1;
			s_next.chip_rst = 1'b1; // [R3]
		end
		// A watchdog chip reset restarts the control bits but keeps the cause flags.
		if (s_next.chip_rst)
		begin
			s_next.lock = 1'b0;
			s_next.run = 1'b0;
			s_next.reset_en = 1'b0;
			s_next.refresh = 1'b0;
			s_next.pre = 16'h0000;
			s_next.feed = wdf_pkg::WDF_IDLE; // [R10]
		end

		s_next.irq = s_reg.irq_enable[wdf_pkg::BIT_WD_IRQ_EN]
			&& |(s_reg.irq_stat & s_reg.irq_mask); // [R14]
		s_next.prio = {s_reg.prio_high[wdf_pkg::BIT_WD_PRIO],
			s_reg.prio_low[wdf_pkg::BIT_WD_PRIO]}; // [R13]
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_reg <= '0;
			s_reg.feed <= wdf_pkg::WDF_IDLE;
			s_reg.status <= 1'b0; // [R8]
			s_reg.reload <= wdf_pkg::RST_BYTE;
			s_reg.irq_stat <= wdf_pkg::RST_IRQ;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	assign prdata = s_reg.rdata;
	assign pready = s_reg.ready;
	assign pslverr = s_reg.slverr;
	assign irq = s_reg.irq;
	assign chip_reset = s_reg.chip_rst;
	assign watchdog_priority = s_reg.prio;
	assign flash_command = s_reg.flash_cmd;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence unfed_flash_wr;
		wr && idx == wdf_pkg::IDX_FLASH_CMD && !fed;
	endsequence

	sequence unfed_ctrl_wr;
		wr && idx == wdf_pkg::IDX_CONTROL && !fed && s_reg.run;
	endsequence

	sequence fed_flash_wr;
		wr && idx == wdf_pkg::IDX_FLASH_CMD && fed;
	endsequence

	sequence fed_ctrl_wr;
		wr && fed && idx == wdf_pkg::IDX_CONTROL && !ovf_rst;
	endsequence

	sequence first_key_wr;
		wr && idx == wdf_pkg::IDX_FEED_FIRST && wd == wdf_pkg::FEED_KEY_FIRST && !ovf_rst;
	endsequence

	sequence start_wr;
		fed_ctrl_wr ##0 !s_reg.run && (wd[wdf_pkg::BIT_RUN] || wd[wdf_pkg::BIT_LOCK]);
	endsequence

	// Writes complete at least three cycles apart, so these gaps leave no room for a stray write.
	sequence feed_then_ctrl;
		first_key_wr ##0 s_reg.feed == wdf_pkg::WDF_IDLE
		##[3:4] wr && idx == wdf_pkg::IDX_FEED_SECOND && wd == wdf_pkg::FEED_KEY_SECOND
		##[3:4] wr && idx == wdf_pkg::IDX_CONTROL && wd[wdf_pkg::BIT_RUN] && !ovf_rst;
	endsequence

	feed_opens_a: assert property (feed_then_ctrl |=> s_reg.run) // [R1]
		else $error("fed control write did not start the watchdog");
	flash_guard_a: assert property (unfed_flash_wr |=> $stable(s_reg.flash_cmd)) // [R2]
		else $error("unfed flash command write changed the register");
	unfed_reset_a: assert property (unfed_ctrl_wr |=> chip_reset && s_reg.feed_err) // [R3] [R5]
		else $error("unfed control write gave no reset or no feed error");
	lock_hold_a: assert property (s_reg.lock |=> s_reg.lock || chip_reset) // [R4]
		else $error("lock-on cleared without a watchdog reset");
	lock_runs_a: assert property (s_reg.lock |-> s_reg.run) // [R4]
		else $error("lock-on set while the watchdog is stopped");
	reset_gate_a: assert property (overflow && !s_reg.reset_en && !unfed_ctrl // [R6]
		|=> !chip_reset)
		else $error("overflow reset the chip while reset is disabled");
	overflow_reset_a: assert property (overflow && s_reg.reset_en // [R6]
		|=> chip_reset ##1 !chip_reset)
		else $error("enabled overflow did not give a one-cycle chip reset");
	overflow_flag_a: assert property (overflow |=> s_reg.status [*2]) // [R7] [R10]
		else $error("status flag not held after overflow");
	status_clear_a: assert property (wr && fed && idx == wdf_pkg::IDX_CONTROL // [R9]
		&& wd[wdf_pkg::BIT_STATUS] && !overflow |=> !s_reg.status)
		else $error("writing one did not clear the status flag");
	refresh_done_a: assert property (s_reg.refresh // [R11] [R16]
		|=> !s_reg.refresh && s_reg.cnt == $past(s_reg.reload))
		else $error("refresh did not reload and self-clear");
	clock_stop_a: assert property (s_reg.clock_gate[wdf_pkg::BIT_CLOCK_STOP] // [R12]
		&& !s_reg.refresh && !wr |=> $stable(s_reg.cnt))
		else $error("counter moved with its clock stopped");
	halted_count_a: assert property (!s_reg.run && !s_reg.refresh && !wr // [R15]
		|=> $stable(s_reg.cnt))
		else $error("counter moved while halted");
	prio_map_a: assert property (##1 watchdog_priority // [R13]
		== {$past(s_reg.prio_high[wdf_pkg::BIT_WD_PRIO]),
		$past(s_reg.prio_low[wdf_pkg::BIT_WD_PRIO])})
		else $error("watchdog priority does not follow its two bits");
	irq_gate_a: assert property (!s_reg.irq_enable[wdf_pkg::BIT_WD_IRQ_EN] |=> !irq) // [R14]
		else $error("interrupt raised while its enable bit is clear");
	feed_half_a: assert property (first_key_wr ##0 s_reg.feed == wdf_pkg::WDF_IDLE // [R1]
		|=> s_reg.feed == wdf_pkg::WDF_HALF)
		else $error("first feed key did not open the feed");
	feed_break_a: assert property (wr && s_reg.feed == wdf_pkg::WDF_HALF // [R1]
		&& !(idx == wdf_pkg::IDX_FEED_SECOND && wd == wdf_pkg::FEED_KEY_SECOND)
		|=> s_reg.feed == wdf_pkg::WDF_IDLE)
		else $error("a stray write did not break the feed");
	feed_spent_a: assert property (wr && fed |=> s_reg.feed == wdf_pkg::WDF_IDLE) // [R1]
		else $error("feed survived the write it guarded");
	feed_hold_a: assert property (!wr && !ovf_rst |=> $stable(s_reg.feed)) // [R1]
		else $error("feed state moved without a write");
	flash_fed_a: assert property (fed_flash_wr |=> s_reg.flash_cmd == $past(wd)) // [R1] [R2]
		else $error("fed flash command write did not land");
	start_reload_a: assert property (start_wr // [R15] [R16]
		|=> s_reg.run && s_reg.cnt == $past(s_reg.reload))
		else $error("start did not run and reload the counter");
	run_halt_a: assert property (fed_ctrl_wr ##0 !wd[wdf_pkg::BIT_RUN] // [R4] [R15]
		&& !wd[wdf_pkg::BIT_LOCK] && !s_reg.lock |=> !s_reg.run)
		else $error("clearing the run bit did not halt the watchdog");
	lock_set_a: assert property (fed_ctrl_wr ##0 wd[wdf_pkg::BIT_LOCK] // [R4]
		|=> s_reg.lock && s_reg.run)
		else $error("lock-on write did not lock and start the watchdog");
	refresh_set_a: assert property (fed_ctrl_wr ##0 wd[wdf_pkg::BIT_REFRESH] // [R11]
		|=> s_reg.refresh)
		else $error("refresh write did not set the refresh bit");
	tick_step_a: assert property (tick && !overflow && !s_reg.refresh && !wr // [R15]
		|=> s_reg.cnt == $past(s_reg.cnt) + 8'h01)
		else $error("counter did not step on its tick");
	ovf_reload_a: assert property (overflow |=> s_reg.cnt == $past(s_reg.reload)) // [R16]
		else $error("overflow did not reload the counter");
	ovf_event_a: assert property (overflow |=> s_reg.irq_stat[wdf_pkg::IRQ_OVERFLOW]) // [R7]
		else $error("overflow did not set its interrupt status");
	feed_event_a: assert property (unfed_ctrl_wr // [R5]
		|=> s_reg.irq_stat[wdf_pkg::IRQ_FEED_ERR])
		else $error("feed error did not set its interrupt status");
	feed_err_kept_a: assert property (s_reg.feed_err && !(wr && fed) |=> s_reg.feed_err) // [R5]
		else $error("feed-error flag lost without a clear");
	status_kept_a: assert property (s_reg.status && !(wr && fed) |=> s_reg.status) // [R7] [R10]
		else $error("status flag lost without a clear");
	chip_cause_a: assert property (!ovf_rst && !unfed_ctrl |=> !chip_reset) // [R3] [R6]
		else $error("chip reset without a watchdog cause");
	irq_level_a: assert property (s_reg.irq_enable[wdf_pkg::BIT_WD_IRQ_EN] // [R14]
		&& |(s_reg.irq_stat & s_reg.irq_mask) |=> irq)
		else $error("enabled pending interrupt not raised");
	stop_prescale_a: assert property (s_reg.clock_gate[wdf_pkg::BIT_CLOCK_STOP] // [R12]
		&& !s_reg.refresh && !wr |=> $stable(s_reg.pre))
		else $error("prescaler moved with its clock stopped");
endmodule : wdf_watchdog
